/* File: hdl/mdc_movx_ctrl.sv */
// Data-move space controller: nonvolatile routing and external data bus
// Summary of operation
// - In-app bit with fuse steers pointer moves to code/signature space
// - Auto-erase bit erases the whole target page before the write
// - Page-load bit only fills the page buffer, no programming starts
// - Nonvolatile programming happens only with write enable set
// - Data memory enable maps nonvolatile data into its space
// - Brownout during programming sets the error flag; software clears
// - Write-inhibit flag follows supply above minimum programming voltage
// - External moves use port 0 muxed, port 2 high on pointer moves, latch/read/write
// - Pointer moves use 16-bit linear address, port 2 held throughout
// - Indirect moves use 8-bit paged address on port 0 only
// - Latch strobe lets external register capture low address byte
// - Ports driven push-pull for address/data, port 0 floats on read
// - Port 0 returns to its configured idle state between accesses
// - Address is stable on port 0, and on port 2 for pointer moves, when latch strobe falls
// - Latch strobe toggles when idle, or released high when disabled
// - Wait-state field stretches read/write strobes by 0 to 3 cycles
// - Erase sets whole page to ones; writes only clear bits
// - Page buffer holds 64 bytes, one half of a 128-byte page
// - Final write address picks half page; buffer clears afterwards
// - No nonvolatile write starts while brownout detector is active
//
// The implementer's own choices: the register offsets and the APB register port.
module mdc_movx_ctrl #(
  parameter int ERASE_CYC = mdc_pkg::NV_ERASE_CYC,
  parameter int PROG_CYC = mdc_pkg::NV_PROG_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [mdc_pkg::APB_AW-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic iap_fuse_i,
  input wire logic bod_active_i,
  input wire logic vdd_prog_ok_i,
  input wire logic req_valid_i,
  input wire mdc_pkg::mdc_req_t req_i,
  output logic ack_o,
  output logic [7:0] rdata_o,
  input wire logic [7:0] p0_i,
  input wire logic [7:0] p0_idle_i,
  input wire logic [7:0] p0_idle_oe_n_i,
  input wire logic [7:0] p2_idle_i,
  input wire logic [7:0] p2_idle_oe_n_i,
  output mdc_pkg::mdc_xbus_t xbus_o
);
  import mdc_pkg::*;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  localparam logic [CNT_W-1:0] ERASE_LOAD = CNT_W'(ERASE_CYC - 1);
  localparam logic [CNT_W-1:0] PROG_LOAD = CNT_W'(PROG_CYC - 1);
  localparam logic [CNT_W-1:0] ALE_LOAD = CNT_W'(ALE_IDLE_CYC - 1);
  logic [7:3] ctrl_reg;
  logic err_reg;
  logic err_next;
  logic [7:0] auxctl_reg;
  mdc_nvstate_t nvs_reg;
  mdc_nvstate_t nvs_next;
  logic [CNT_W-1:0] nv_cnt_reg;
  logic [CNT_W-1:0] nv_cnt_next;
  logic [2:0] tgt_reg;
  logic nv_ack_reg;
  logic [7:0] nv_rd_reg;
  logic [HALF_BYTES-1:0] bufv_reg;
  logic [7:0] pbuf [HALF_BYTES];
  logic [7:0] nv_mem [2*NV_BANK_BYTES];
  mdc_xstate_t xs_reg;
  mdc_xstate_t xs_next;
  logic [1:0] xcnt_reg;
  mdc_req_t xreq_reg;
  logic [7:0] x_rd_reg;
  logic ale_tog_reg;
  logic [CNT_W-1:0] ale_div_reg;
  // Register bus decode; every access completes with no wait state
  wire apb_acc = psel_i & penable_i;
  wire hit_mc = paddr_i == MEMCTL_OFS;
  wire hit_ax = paddr_i == AUXCTL_OFS;
  wire mc_wr = apb_acc & pwrite_i & hit_mc & pstrb_i[0];
  wire ax_wr = apb_acc & pwrite_i & hit_ax & pstrb_i[0];
  wire busy = nvs_reg != NS_IDLE;
  wire [7:0] memctl_view = {ctrl_reg, err_reg, busy, vdd_prog_ok_i};
  wire [7:0] rd_byte = hit_mc ? memctl_view :
                       hit_ax ? auxctl_reg : '0;
  assign pready_o = 1'b1;
  assign pslverr_o = apb_acc & ~hit_mc & ~hit_ax;
  assign prdata_o = (apb_acc & ~pwrite_i) ? {24'h00_0000, rd_byte} : '0;
  // Core request routing
  wire iap_eff = ctrl_reg[MC_IAP] & iap_fuse_i;
  wire flash_data_space_hit = ctrl_reg[MC_NV_DATA_MAP_ENABLE] & (req_i.addr[15:8] == FLASH_DATA_SPACE_HI);
  wire nv_hit = req_i.linear & (iap_eff | flash_data_space_hit);
  wire take = req_valid_i & ~ack_o & (xs_reg == XS_IDLE) & ~busy;
  wire nv_take = take & nv_hit;
  wire x_take = take & ~nv_hit;
  wire nv_wr = nv_take & req_i.write & ctrl_reg[MC_NV_WRITE_ENABLE];
  wire nv_load = nv_wr & ctrl_reg[MC_PAGE_LOAD_ENABLE];
  wire nv_fire = nv_wr & ~ctrl_reg[MC_PAGE_LOAD_ENABLE];
  wire nv_start = nv_fire & ~bod_active_i;
  wire nv_abort = busy & bod_active_i;
  wire cnt_done = nv_cnt_reg == '0;
  wire erase_done = (nvs_reg == NS_ERASE) & cnt_done & ~bod_active_i;
  wire prog_done = (nvs_reg == NS_PROG) & cnt_done & ~bod_active_i;
  wire buf_clr = prog_done | nv_abort | (nv_fire & bod_active_i);
  wire [8:0] rd_idx = {iap_eff, req_i.addr[7:0]};
  wire [1:0] ws_sel = auxctl_reg[AX_WS_HI:AX_WS_LO];
  wire lsd = auxctl_reg[AX_LSD];
  assign ack_o = nv_ack_reg | (xs_reg == XS_DONE);
  assign rdata_o = (xs_reg == XS_DONE) ? x_rd_reg : nv_rd_reg;
  // Brownout sets, a software zero clears; the set wins in a tie
  assign err_next = nv_abort |
                    (err_reg & ~(mc_wr & ~pwdata_i[MC_ERR]));
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= MEMCTL_RST[7:3];
      err_reg <= MEMCTL_RST[MC_ERR];
      auxctl_reg <= AUXCTL_RST;
    end else begin
      err_reg <= err_next;
      if (mc_wr) begin
        ctrl_reg <= pwdata_i[7:3];
      end
      if (ax_wr) begin
        auxctl_reg <= pwdata_i[7:0] & AUXCTL_MASK;
      end
    end
  end

  // Nonvolatile sequencer: optional erase, then half-page program
  always_comb begin
    nvs_next = nvs_reg;
    nv_cnt_next = cnt_done ? nv_cnt_reg : nv_cnt_reg - 1'b1;
    case (nvs_reg)
      NS_IDLE: begin
        if (nv_start) begin
          nvs_next = ctrl_reg[MC_AUTO_ERASE_ENABLE] ? NS_ERASE : NS_PROG;
          nv_cnt_next = ctrl_reg[MC_AUTO_ERASE_ENABLE] ? ERASE_LOAD : PROG_LOAD;
        end
      end
      NS_ERASE: begin
        if (bod_active_i) begin
          nvs_next = NS_IDLE;
        end else if (cnt_done) begin
          nvs_next = NS_PROG;
          nv_cnt_next = PROG_LOAD;
        end
      end
      NS_PROG: begin
        if (bod_active_i | cnt_done) begin
          nvs_next = NS_IDLE;
        end
      end
      default: begin
        nvs_next = NS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      nvs_reg <= NS_IDLE;
      nv_cnt_reg <= '0;
      tgt_reg <= '0;
      nv_ack_reg <= 1'b0;
      nv_rd_reg <= '0;
      bufv_reg <= '0;
    end else begin
      nvs_reg <= nvs_next;
      nv_cnt_reg <= nv_cnt_next;
      nv_ack_reg <= nv_take;
      if (nv_take & ~req_i.write) begin
        nv_rd_reg <= nv_mem[rd_idx];
      end
      if (nv_start) begin
        tgt_reg <= {iap_eff, req_i.addr[7:6]};
      end
      if (buf_clr) begin
        bufv_reg <= '0;
      end else if (nv_wr) begin
        bufv_reg[req_i.addr[5:0]] <= 1'b1;
      end
    end
  end

  // Array contents carry no reset, as in a real flash array
  always_ff @(posedge mclk_i) begin
    if (nv_wr) begin
      pbuf[req_i.addr[5:0]] <= req_i.wdata;
    end
    for (int i = 0; i < PAGE_BYTES; i++) begin
      if (erase_done) begin
        nv_mem[{tgt_reg[2:1], 7'(i)}] <= ERASED_BYTE;
      end
    end
    for (int j = 0; j < HALF_BYTES; j++) begin
      if (prog_done && bufv_reg[j]) begin
        nv_mem[{tgt_reg, 6'(j)}] <=
          nv_mem[{tgt_reg, 6'(j)}] & pbuf[j];
      end
    end
  end

  // External bus cycle: address, latch, stretched strobe, done
  always_comb begin
    xs_next = xs_reg;
    case (xs_reg)
      XS_IDLE: begin
        if (x_take) begin
          xs_next = XS_ADDR;
        end
      end
      XS_ADDR: begin
        xs_next = XS_LATCH;
      end
      XS_LATCH: begin
        xs_next = XS_STROBE;
      end
      XS_STROBE: begin
        if (xcnt_reg == '0) begin
          xs_next = XS_DONE;
        end
      end
      default: begin
        xs_next = XS_IDLE;
      end
    endcase
  end
  wire ale_tick = (xs_reg == XS_IDLE) & (ale_div_reg == ALE_LOAD);
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      xs_reg <= XS_IDLE;
      xcnt_reg <= '0;
      xreq_reg <= '0;
      x_rd_reg <= '0;
      ale_tog_reg <= 1'b0;
      ale_div_reg <= '0;
    end else begin
      xs_reg <= xs_next;
      xcnt_reg <= (xs_reg == XS_LATCH) ? ws_sel : xcnt_reg - 1'b1;
      if (x_take) begin
        xreq_reg <= req_i;
      end
      if ((xs_reg == XS_STROBE) & (xcnt_reg == '0) & ~xreq_reg.write) begin
        x_rd_reg <= p0_i;
      end
      ale_div_reg <= (ale_tick | (xs_reg != XS_IDLE)) ? '0 :
                     ale_div_reg + 1'b1;
      if (ale_tick) begin
        ale_tog_reg <= ~ale_tog_reg;
      end
    end
  end
  // Pin drive; port 0 idle state comes from its port configuration
  wire x_adr = (xs_reg == XS_ADDR) | (xs_reg == XS_LATCH);
  wire x_stb = xs_reg == XS_STROBE;
  wire x_act = x_adr | x_stb;
  wire x_rd_ph = x_stb & ~xreq_reg.write;
  wire p2_drv = x_act & xreq_reg.linear;
  assign xbus_o.p0 = x_adr ? xreq_reg.addr[7:0] :
                     x_stb ? xreq_reg.wdata : p0_idle_i;
  assign xbus_o.p0_oe_n = ~x_act ? p0_idle_oe_n_i :
                          x_rd_ph ? '1 : '0;
  assign xbus_o.p2 = p2_drv ? xreq_reg.addr[15:8] : p2_idle_i;
  assign xbus_o.p2_oe_n = p2_drv ? '0 : p2_idle_oe_n_i;
  // A disabled strobe is released so the weak pull-up holds it high
  assign xbus_o.ale = (xs_reg == XS_ADDR) |
                      (~x_act & (lsd | ale_tog_reg));
  assign xbus_o.ale_oe_n = ~x_act & lsd;
  assign xbus_o.rd_n = ~x_rd_ph;
  assign xbus_o.wr_n = ~(x_stb & xreq_reg.write);
  // Checks
  logic [2:0] sw_cnt_reg;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_cnt_reg <= '0;
    end else begin
      sw_cnt_reg <= x_stb ? sw_cnt_reg + 1'b1 : '0;
    end
  end

  sequence s_addr_then_latch;
    xs_reg == XS_ADDR ##1 xs_reg == XS_LATCH;
  endsequence
  sequence s_strobe_end;
    xs_reg == XS_STROBE ##1 xs_reg == XS_DONE;
  endsequence

  ale_fall_addr_a: assert property (
    s_addr_then_latch |-> $fell(xbus_o.ale) && $stable(xbus_o.p0) &&
      $stable(xbus_o.p2) && xbus_o.p0_oe_n == '0)
    else $error("address not stable at latch fall");
  strobe_width_a: assert property (
    s_strobe_end |-> sw_cnt_reg == 3'(ws_sel) + 3'd1)
    else $error("strobe width differs from wait-state setting");
  read_float_a: assert property (
    x_rd_ph |-> xbus_o.p0_oe_n == '1 && !xbus_o.rd_n && xbus_o.wr_n)
    else $error("port 0 driven during read strobe");
  idle_port_a: assert property (
    xs_reg == XS_IDLE |-> xbus_o.p0 == p0_idle_i &&
      xbus_o.p0_oe_n == p0_idle_oe_n_i)
    else $error("port 0 not at idle configuration");
  linear_hold_a: assert property (
    xs_reg == XS_ADDR && xreq_reg.linear |->
      xbus_o.p2 == xreq_reg.addr[15:8] ##1 $stable(xbus_o.p2) ##1
      $stable(xbus_o.p2) && xbus_o.p2_oe_n == '0)
    else $error("upper address not held on port 2");
  paged_p2_a: assert property (
    x_act && !xreq_reg.linear |-> xbus_o.p2_oe_n == p2_idle_oe_n_i)
    else $error("port 2 driven in paged mode");
  wen_gate_a: assert property (
    nv_take && req_i.write && !ctrl_reg[MC_NV_WRITE_ENABLE] |=>
      nvs_reg == NS_IDLE && $stable(bufv_reg))
    else $error("programming without write enable");
  page_load_a: assert property (
    nv_load |=> nvs_reg == NS_IDLE && !memctl_view[MC_BUSY])
    else $error("page load started a sequence");
  erase_first_a: assert property (
    nv_start && ctrl_reg[MC_AUTO_ERASE_ENABLE] |=> nvs_reg == NS_ERASE)
    else $error("auto-erase not started");
  bod_block_a: assert property (
    nv_fire && bod_active_i |=> nvs_reg == NS_IDLE && bufv_reg == '0)
    else $error("write started under brownout");
  err_set_a: assert property (
    nv_abort |=> err_reg && nvs_reg == NS_IDLE)
    else $error("brownout abort did not flag error");
endmodule

/* File: inc/mdc_pkg.sv */
// Constants, types and register map of the data-move space controller
package mdc_pkg;
  localparam int CLK_NS = 20;
  localparam int APB_AW = 8;
  localparam int CNT_W = 16;
  localparam logic [APB_AW-1:0] MEMCTL_OFS = 8'h00;
  localparam logic [APB_AW-1:0] AUXCTL_OFS = 8'h04;
  localparam logic [7:0] MEMCTL_RST = 8'h00;
  localparam logic [7:0] AUXCTL_RST = 8'h00;
  localparam logic [7:0] AUXCTL_MASK = 8'h0d;
  localparam int MC_IAP = 7;
  localparam int MC_AUTO_ERASE_ENABLE = 6;
  localparam int MC_PAGE_LOAD_ENABLE = 5;
  localparam int MC_NV_WRITE_ENABLE = 4;
  localparam int MC_NV_DATA_MAP_ENABLE = 3;
  localparam int MC_ERR = 2;
  localparam int MC_BUSY = 1;
  localparam int MC_WINH = 0;
  localparam int AX_LSD = 0;
  localparam int AX_WS_LO = 2;
  localparam int AX_WS_HI = 3;
  localparam int ALE_IDLE_NS = 40;
  localparam int ALE_IDLE_CYC =
    (ALE_IDLE_NS / CLK_NS < 1) ? 1 : ALE_IDLE_NS / CLK_NS;
  localparam int NV_ERASE_NS = 2000;
  localparam int NV_PROG_NS = 2000;
  localparam int NV_ERASE_CYC = (NV_ERASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int NV_PROG_CYC = (NV_PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int NV_BANK_BYTES = 256;
  localparam int PAGE_BYTES = 128;
  localparam int HALF_BYTES = 64;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] FLASH_DATA_SPACE_HI = 8'h00;

  typedef enum logic [2:0] {
    XS_IDLE = 3'b000,
    XS_ADDR = 3'b001,
    XS_LATCH = 3'b010,
    XS_STROBE = 3'b011,
    XS_DONE = 3'b100
  } mdc_xstate_t;

  typedef enum logic [1:0] {
    NS_IDLE = 2'b00,
    NS_ERASE = 2'b01,
    NS_PROG = 2'b10
  } mdc_nvstate_t;

  typedef struct packed {
    logic write;
    logic linear;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mdc_req_t;

  typedef struct packed {
    logic [7:0] p0;
    logic [7:0] p0_oe_n;
    logic [7:0] p2;
    logic [7:0] p2_oe_n;
    logic ale;
    logic ale_oe_n;
    logic rd_n;
    logic wr_n;
  } mdc_xbus_t;
endpackage

/* File: bench/mdc_xram_model.sv */
// External RAM with its low-address latch, seen from the bus pins
module mdc_xram_model (
  input wire logic mclk_i,
  input wire mdc_pkg::mdc_xbus_t xbus_i,
  output logic [7:0] p0_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import mdc_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] lat;
  logic [7:0] last = 8'h5a;
  wire [15:0] ram_addr = {xbus_i.p2, lat};
  // Undriven lines flip every cycle so a stale byte never reads as valid
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (!xbus_i.p0_oe_n[b]) p0_o[b] = xbus_i.p0[b];
      else if (!xbus_i.rd_n) p0_o[b] = mem[ram_addr][b];
      else p0_o[b] = ~last[b];
    end
  end
  always @(negedge xbus_i.ale) lat <= p0_o;
  always @(posedge mclk_i) begin
    last <= p0_o;
    if (!xbus_i.wr_n) mem[ram_addr] <= p0_o;
  end
endmodule

/* File: bench/mdc_movx_ctrl_tb.sv */
// Self-checking bench for the data-move space controller
module mdc_movx_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mdc_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] paddr_i = 8'h00;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, ack_o, s;
  logic bod_active_i = 1'b0;
  logic iap_fuse_i = 1'b0;
  logic vdd_prog_ok_i = 1'b1;
  logic req_valid_i = 1'b0;
  mdc_req_t req_i = '0;
  logic [7:0] rdata_o, p0_i, d, r;
  logic [7:0] p0_idle_i = 8'ha5;
  logic [7:0] p0_idle_oe_n_i = 8'h0f;
  logic [7:0] p2_idle_i = 8'h00;
  logic [7:0] p2_idle_oe_n_i = 8'hf0;
  mdc_xbus_t xbus_o;
  logic [31:0] v;
  logic [15:0] a;
  int err_count = 0;
  int n_tests = 0;
  int n, sw;

  always #(CLK_NS / 2) mclk_i = ~mclk_i;

  // Short erase and program counts keep the run brief
  mdc_movx_ctrl #(.ERASE_CYC(8), .PROG_CYC(8)) u_mdc_movx_ctrl (
    .mclk_i(mclk_i), .rst_i(rst_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
    .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .iap_fuse_i(iap_fuse_i),
    .bod_active_i(bod_active_i),
    .vdd_prog_ok_i(vdd_prog_ok_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .ack_o(ack_o), .rdata_o(rdata_o), .p0_i(p0_i),
    .p0_idle_i(p0_idle_i), .p0_idle_oe_n_i(p0_idle_oe_n_i),
    .p2_idle_i(p2_idle_i), .p2_idle_oe_n_i(p2_idle_oe_n_i),
    .xbus_o(xbus_o));
  mdc_xram_model u_mdc_xram_model (
    .mclk_i(mclk_i), .xbus_i(xbus_o), .p0_o(p0_i));

  function automatic int ext_cyc(input int ws);
    return 5 + ws;
  endfunction
  function automatic int strobe_w(input int ws);
    return 1 + ws;
  endfunction
  function automatic logic [7:0] nv_prog(input logic [7:0] o, w);
    return o & w;
  endfunction

  task automatic chk(input logic [31:0] g, e, input string m);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %0t %s", $time, m);
      err_count++;
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] ad, wd,
                     output logic [31:0] rv, output logic se);
    int k;
    logic rdy;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= {24'h00_0000, wd};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk_i);
      rdy = pready_o;
      rv = prdata_o;
      se = pslverr_o;
      k++;
    end while (rdy !== 1'b1 && k < 100);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (rdy !== 1'b1) begin
      chk(0, 1, "apb timeout");
      results();
    end
    @(posedge mclk_i);
  endtask

  task automatic rg(input logic [7:0] ad, output logic [31:0] rv);
    logic se;
    apb(1'b0, ad, 8'h00, rv, se);
  endtask
  task automatic wg(input logic [7:0] ad, wd);
    logic [31:0] rv;
    logic se;
    apb(1'b1, ad, wd, rv, se);
  endtask

  task automatic core(input logic w, lin, input logic [15:0] ad,
                      input logic [7:0] wd, output logic [7:0] rd);
    logic got;
    req_valid_i <= 1'b1;
    req_i <= '{w, lin, ad, wd};
    n = 0;
    sw = 0;
    got = 1'b0;
    do begin
      @(posedge mclk_i);
      n++;
      got = ack_o === 1'b1;
      if (!xbus_o.rd_n || !xbus_o.wr_n) begin
        sw++;
        chk({xbus_o.p2, xbus_o.p2_oe_n}, lin ? {ad[15:8], 8'h00} :
            {p2_idle_i, p2_idle_oe_n_i}, "p2 drive");
        chk(xbus_o.p0_oe_n, w ? 8'h00 : 8'hff, "p0 drive");
      end
    end while (!got && n < 300);
    rd = rdata_o;
    if (!got) begin
      chk(0, 1, "ack timeout");
      results();
    end
    req_valid_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      rg(MEMCTL_OFS, v);
      k++;
    end while (v[1] !== 1'b0 && k < 50);
    if (k >= 50) begin
      chk(0, 1, "busy timeout");
      results();
    end
  endtask

  initial begin
    void'($urandom(32'hce24e9b6));
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rg(MEMCTL_OFS, v);
    chk(v, 32'h0000_0001, "memctl reset");
    vdd_prog_ok_i <= 1'b0;
    rg(MEMCTL_OFS, v);
    chk(v, 32'h0000_0000, "inhibit low");
    vdd_prog_ok_i <= 1'b1;
    wg(AUXCTL_OFS, 8'hff);
    rg(AUXCTL_OFS, v);
    chk(v, 32'h0000_000d, "aux bits");
    apb(1'b0, 8'h08, 8'h00, v, s);
    chk(v, 32'h0000_0000, "unmapped read");
    chk(s, 1'b1, "unmapped error");
    @(posedge mclk_i);
    chk({xbus_o.ale, xbus_o.ale_oe_n}, 2'b11, "ale released");
    wg(AUXCTL_OFS, 8'h00);
    n = 0;
    r[0] = xbus_o.ale;
    repeat (8) begin
      @(posedge mclk_i);
      if (xbus_o.ale !== r[0]) n++;
      r[0] = xbus_o.ale;
    end
    chk(n >= 3, 1, "ale idle toggle");
    $display("registers and strobe idle done");
    for (int ws = 0; ws < 4; ws++) begin
      wg(AUXCTL_OFS, 8'(ws << 2));
      a = 16'($urandom);
      d = 8'($urandom);
      core(1'b1, 1'b1, a, d, r);
      chk(n, ext_cyc(ws), "write ack");
      chk(sw, strobe_w(ws), "write strobe");
      core(1'b0, 1'b1, a, 8'h00, r);
      chk(r, d, "linear read");
      chk(sw, strobe_w(ws), "read strobe");
      chk(u_mdc_xram_model.lat, a[7:0], "latched");
      chk({xbus_o.p0, xbus_o.p0_oe_n}, {p0_idle_i, p0_idle_oe_n_i},
          "p0 idle");
      p2_idle_i <= 8'($urandom);
      core(1'b1, 1'b0, {8'h00, a[7:0]}, ~d, r);
      core(1'b0, 1'b1, {p2_idle_i, a[7:0]}, 8'h00, r);
      chk(r, 8'(~d), "paged write");
      $display("external ws %0d done", ws);
    end
    wg(MEMCTL_OFS, 8'h78);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) wg(MEMCTL_OFS, 8'h58);
      core(1'b1, 1'b1, 16'h0040 + 16'(i), 8'h10 + 8'(i), r);
      chk(n, 2, "nv ack");
      rg(MEMCTL_OFS, v);
      chk(v[1], i == 4, "busy");
    end
    wait_idle();
    for (int i = 0; i < 5; i++) begin
      core(1'b0, 1'b1, 16'h0040 + 16'(i), 8'h00, r);
      chk(r, 8'h10 + 8'(i), "page data");
    end
    core(1'b0, 1'b1, 16'h0045, 8'h00, r);
    chk(r, 8'hff, "erased high");
    core(1'b0, 1'b1, 16'h0000, 8'h00, r);
    chk(r, 8'hff, "erased low");
    $display("page write done");
    wg(MEMCTL_OFS, 8'h18);
    core(1'b1, 1'b1, 16'h0050, 8'h3c, r);
    wait_idle();
    core(1'b1, 1'b1, 16'h0050, 8'hc6, r);
    wait_idle();
    wg(MEMCTL_OFS, 8'h08);
    core(1'b1, 1'b1, 16'h0050, 8'h00, r);
    core(1'b0, 1'b1, 16'h0050, 8'h00, r);
    chk(r, nv_prog(nv_prog(8'hff, 8'h3c), 8'hc6), "and write");
    bod_active_i <= 1'b1;
    wg(MEMCTL_OFS, 8'h18);
    core(1'b1, 1'b1, 16'h0045, 8'h00, r);
    wait_idle();
    core(1'b0, 1'b1, 16'h0045, 8'h00, r);
    chk(r, 8'hff, "bod start");
    bod_active_i <= 1'b0;
    wg(MEMCTL_OFS, 8'h58);
    core(1'b1, 1'b1, 16'h0060, 8'h00, r);
    repeat (2) @(posedge mclk_i);
    bod_active_i <= 1'b1;
    wait_idle();
    chk(v[2], 1'b1, "error set");
    bod_active_i <= 1'b0;
    wg(MEMCTL_OFS, 8'h18);
    rg(MEMCTL_OFS, v);
    chk(v[2], 1'b0, "error clear");
    iap_fuse_i <= 1'b1;
    wg(MEMCTL_OFS, 8'hd0);
    core(1'b1, 1'b1, 16'h1234, 8'h5a, r);
    wait_idle();
    core(1'b0, 1'b1, 16'h1234, 8'h00, r);
    chk(r, 8'h5a, "in-app space");
    wg(MEMCTL_OFS, 8'h08);
    core(1'b0, 1'b1, 16'h0040, 8'h00, r);
    chk(r, 8'h10, "data space back");
    iap_fuse_i <= 1'b0;
    wg(MEMCTL_OFS, 8'h80);
    core(1'b0, 1'b1, 16'h1234, 8'h00, r);
    chk(n, ext_cyc(3), "fuse off");
    wg(MEMCTL_OFS, 8'h00);
    core(1'b0, 1'b1, 16'h0050, 8'h00, r);
    chk(n, ext_cyc(3), "unmapped data");
    $display("nonvolatile done");
    results();
  end
endmodule
